//--- logic/fcp_flash_seq.sv
`timescale 1ns/1ps
module fcp_flash_seq #(
  parameter int unsigned FIFO_DEPTH = fcp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // cpu bus write cycles
  input wire logic busWrValid,
  input wire logic [31:0] busWrAddr,
  input wire logic [31:0] busWrData,
  output logic busWrReady,
  // cpu bus read strobe into flash space
  input wire logic busRdStrobe,
  // flash array programming port
  output logic cellWrValid,
  output logic [31:0] cellWrAddr,
  output logic [31:0] cellClearMask,
  input wire logic cellWrReady,
  input wire logic cellWrFail,
  // block protection lookup for the current page
  output logic [31:0] pageAddr,
  input wire logic pageProtected,
  // status
  output logic readyBusyFlag,
  output logic readMode,
  output logic failLocked
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (FIFO_DEPTH < 2) begin : gDepthCheck
    $error("fcp_flash_seq needs a write buffer of at least 2 words");
  end
  if ((1 << fcp_pkg::IDX_W) != fcp_pkg::PAGE_WORDS) begin : gPageCheck
    $error("fcp_flash_seq page geometry does not match word count");
  end

  // ----------------------------------------------------------------
  // write cycle buffer
  // ----------------------------------------------------------------
  logic fifoOutValid;
  logic fifoOutReady;
  logic [63:0] fifoOutData;
  logic [31:0] cycAddr;
  logic [31:0] cycData;
  logic take;

  fcp_fifo #(
    .WIDTH(64),
    .DEPTH(FIFO_DEPTH)
  ) uBuf (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(busWrValid),
    .inData({busWrAddr, busWrData}),
    .inReady(busWrReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoOutReady)
  );

  assign cycAddr = fifoOutData[63:32];
  assign cycData = fifoOutData[31:0];
  assign take = fifoOutValid && fifoOutReady;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_READ,
    ST_KEY1,
    ST_KEY2,
    ST_PRG_ADDR,
    ST_PRG_CHECK,
    ST_PRG_DATA,
    ST_PRG_DRAIN,
    ST_FAIL
  } fcp_state_e;

  fcp_state_e state_q, state_d;
  logic [22:0] pageBase_q, pageBase_d;
  logic [6:0] wordIdx_q, wordIdx_d;
  logic wrValid_q, wrValid_d;
  logic [31:0] wrAddr_q, wrAddr_d;
  logic [31:0] wrMask_q, wrMask_d;
  logic prot_q, prot_d;
  logic rdyBsy_q, rdyBsy_d;
  logic stageFree;
  logic keyAddrA;
  logic keyAddrB;
  logic busyNext;

  assign keyAddrA = (cycAddr[15:0] == fcp_pkg::KEY_ADDR_A);
  assign keyAddrB = (cycAddr[15:0] == fcp_pkg::KEY_ADDR_B);
  // the write stage can take a word if empty or being emptied
  assign stageFree = !wrValid_q || cellWrReady;

  // pop policy per state; drain state holds later writes back
  always_comb begin
    unique case (state_q)
      ST_READ, ST_KEY1, ST_KEY2: fifoOutReady = 1'b1;
      ST_PRG_ADDR, ST_PRG_DATA: fifoOutReady = stageFree;
      ST_PRG_CHECK, ST_PRG_DRAIN: fifoOutReady = 1'b0;
      ST_FAIL: fifoOutReady = 1'b1; // discard so the cpu bus never hangs
    endcase
  end

  // next state and datapath values
  always_comb begin
    state_d = state_q;
    pageBase_d = pageBase_q;
    wordIdx_d = wordIdx_q;
    wrValid_d = wrValid_q && !cellWrReady;
    wrAddr_d = wrAddr_q;
    wrMask_d = wrMask_q;
    prot_d = prot_q;
    unique case (state_q)
      // read mode: only the first key or a single read command count
      ST_READ: begin
        if (take) begin
          if (cycData == fcp_pkg::CMD_READ) begin
            state_d = ST_READ;
          end else if (keyAddrA && cycData == fcp_pkg::KEY_DATA_1) begin
            state_d = ST_KEY1;
          end else begin
            state_d = ST_READ;
          end
        end
      end
      // a stray read mid-sequence would confuse decoding, so abort
      ST_KEY1: begin
        if (busRdStrobe) begin
          state_d = ST_READ;
        end else if (take) begin
          if (cycData == fcp_pkg::CMD_READ) begin
            state_d = ST_READ;
          end else if (keyAddrB && cycData == fcp_pkg::KEY_DATA_2) begin
            state_d = ST_KEY2;
          end else begin
            state_d = ST_READ;
          end
        end
      end
      // third cycle selects the operation
      ST_KEY2: begin
        if (busRdStrobe) begin
          state_d = ST_READ;
        end else if (take) begin
          if (keyAddrA && cycData == fcp_pkg::CMD_PAGE_PROG) begin
            state_d = ST_PRG_ADDR;
          end else if (cycData == fcp_pkg::CMD_READ) begin
            state_d = ST_READ;
          end else begin
            state_d = ST_READ;
          end
        end
      end
      // fourth cycle: page top address and first word
      ST_PRG_ADDR: begin
        if (take) begin
          pageBase_d = cycAddr[31:fcp_pkg::PAGE_LSB];
          wrAddr_d = {cycAddr[31:fcp_pkg::PAGE_LSB], 9'h000};
          wrMask_d = ~cycData;
          wordIdx_d = fcp_pkg::FIRST_DATA_IDX;
          state_d = ST_PRG_CHECK;
        end
      end
      // one cycle for the protection lookup of the new page
      ST_PRG_CHECK: begin
        prot_d = pageProtected;
        wrValid_d = !pageProtected;
        state_d = ST_PRG_DATA;
      end
      // every cycle is page data; commands here are just data
      ST_PRG_DATA: begin
        if (take) begin
          wrAddr_d = {pageBase_q, wordIdx_q, 2'b00};
          wrMask_d = ~cycData;
          wrValid_d = !prot_q;
          wordIdx_d = wordIdx_q + 7'h01;
          if (wordIdx_q == fcp_pkg::LAST_WORD_IDX) begin
            state_d = ST_PRG_DRAIN;
          end
        end
      end
      // last word in flight: finish once the array has it
      ST_PRG_DRAIN: begin
        if (!wrValid_d) begin
          state_d = ST_READ;
        end
      end
      // locked: only rst leaves this state
      ST_FAIL: begin
        wrValid_d = 1'b0;
      end
    endcase
    // a failure report from the array overrides any progress
    if (cellWrFail && (state_q == ST_PRG_ADDR || state_q == ST_PRG_CHECK ||
        state_q == ST_PRG_DATA || state_q == ST_PRG_DRAIN)) begin
      state_d = ST_FAIL;
      wrValid_d = 1'b0;
    end
  end

  // ready/busy follows the next state so it drops with the third cycle
  always_comb begin
    busyNext = (state_d == ST_PRG_ADDR) || (state_d == ST_PRG_CHECK) ||
               (state_d == ST_PRG_DATA) || (state_d == ST_PRG_DRAIN) ||
               (state_d == ST_FAIL);
    rdyBsy_d = !busyNext;
  end

  // sequencer registers; cpu reset returns everything to read mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_READ;
      pageBase_q <= '0;
      wordIdx_q <= '0;
      wrValid_q <= 1'b0;
      wrAddr_q <= '0;
      wrMask_q <= '0;
      prot_q <= 1'b0;
      rdyBsy_q <= fcp_pkg::READY_BUSY_FLAG_RESET;
    end else begin
      state_q <= state_d;
      pageBase_q <= pageBase_d;
      wordIdx_q <= wordIdx_d;
      wrValid_q <= wrValid_d;
      wrAddr_q <= wrAddr_d;
      wrMask_q <= wrMask_d;
      prot_q <= prot_d;
      rdyBsy_q <= rdyBsy_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cellWrValid = wrValid_q;
  assign cellWrAddr = wrAddr_q;
  assign cellClearMask = wrMask_q; // ones mark cells pulled to zero
  assign pageAddr = {pageBase_q, 9'h000};
  assign readyBusyFlag = rdyBsy_q; // status bit 0
  assign readMode = rdyBsy_q;
  assign failLocked = (state_q == ST_FAIL);

endmodule

//--- pkg/fcp_pkg.sv
// ----------------------------------------------------------------
// flash command sequencer constants
// ----------------------------------------------------------------
package fcp_pkg;

  // bus widths
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // unlock key addresses, compared on the low address half
  localparam logic [15:0] KEY_ADDR_A = 16'h5554;
  localparam logic [15:0] KEY_ADDR_B = 16'hAAAA;

  // command data words
  localparam logic [31:0] KEY_DATA_1 = 32'h000000AA;
  localparam logic [31:0] KEY_DATA_2 = 32'h00000055;
  localparam logic [31:0] CMD_PAGE_PROG = 32'h000000A0;
  localparam logic [31:0] CMD_READ = 32'h000000F0;

  // page geometry: 128 words sharing address [31:9]
  localparam int unsigned PAGE_WORDS = 128;
  localparam int unsigned PAGE_LSB = 9;
  localparam int unsigned WORD_LSB = 2;
  localparam int unsigned IDX_W = PAGE_LSB - WORD_LSB;
  localparam logic [6:0] LAST_WORD_IDX = 7'h7F;
  localparam logic [6:0] FIRST_DATA_IDX = 7'h01;

  // write buffer depth in front of the sequencer
  localparam int unsigned FIFO_DEPTH = 16;

  // reset values
  localparam logic READY_BUSY_FLAG_RESET = 1'b1;

endpackage

//--- logic/fcp_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// synchronous first-word-fall-through fifo
// ----------------------------------------------------------------
module fcp_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : gDepthCheck
    $error("fcp_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [PTR_W:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic doPush, doPop;

  // full when pointers differ only in the wrap bit
  assign inReady = !((wrPtr_q[PTR_W] != rdPtr_q[PTR_W]) &&
                     (wrPtr_q[PTR_W-1:0] == rdPtr_q[PTR_W-1:0]));
  assign outValid = (wrPtr_q != rdPtr_q);
  assign outData = memQ[rdPtr_q[PTR_W-1:0]];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // pointer next values
  always_comb begin
    wrPtr_d = wrPtr_q + (PTR_W+1)'(doPush);
    rdPtr_d = rdPtr_q + (PTR_W+1)'(doPop);
  end

  // pointer registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  // storage, no reset needed: never read while empty
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      memQ[wrPtr_q[PTR_W-1:0]] <= inData;
    end
  end

endmodule

//--- testbench/fcp_seq_monitor.sv
`timescale 1ns/1ps
// ----------
// sequencer port checks
// ----------
module fcp_seq_monitor #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // cpu bus
  input wire logic busWrValid,
  input wire logic [31:0] busWrAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrReady,
  input wire logic busRdStrobe,
  // array port
  input wire logic cellWrValid,
  input wire logic [31:0] cellWrAddr,
  input wire logic [31:0] cellClearMask,
  input wire logic cellWrReady,
  input wire logic cellWrFail,
  input wire logic [31:0] pageAddr,
  input wire logic pageProtected,
  // status
  input wire logic readyBusyFlag,
  input wire logic readMode,
  input wire logic failLocked
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // array handshake steps
  sequence s_take;
    cellWrValid && cellWrReady;
  endsequence
  // a failure report withdraws the request, so it is not a stall
  sequence s_stall;
    cellWrValid && !cellWrReady && !cellWrFail;
  endsequence
  a_mode_mirror: assert property (readMode == readyBusyFlag)
    else $error("read mode differs from ready flag");
  a_write_busy: assert property (cellWrValid |-> !readyBusyFlag)
    else $error("array write while ready");
  a_stall_hold: assert property (s_stall |=> cellWrValid && $stable(cellWrAddr)
    && $stable(cellClearMask)) else $error("array request dropped or changed");
  a_page_match: assert property (cellWrValid |-> cellWrAddr[31:9] == pageAddr[31:9]
    && cellWrAddr[1:0] == 2'h0) else $error("write outside current page");
  a_addr_step: assert property (s_take ##1 cellWrValid |->
    cellWrAddr == $past(cellWrAddr) + 32'h4) else $error("word address not sequential");
  a_last_done: assert property (cellWrValid && cellWrReady && cellWrAddr[8:2] == 7'h7F
    |=> readyBusyFlag) else $error("not ready after last word");
  a_fail_enter: assert property (cellWrFail && !readyBusyFlag |=> failLocked
    && !cellWrValid) else $error("failure not locked");
  a_fail_hold: assert property (failLocked |=> failLocked && !readyBusyFlag)
    else $error("failure lock left without reset");
  a_ready_end: assert property ($rose(readyBusyFlag) |-> !failLocked && !cellWrValid)
    else $error("ready raised with work pending");
  c_back_pressure: cover property (s_take ##1 s_stall);
endmodule
bind fcp_flash_seq fcp_seq_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_mon (
  .ref_clk(ref_clk),
  .rst(rst),
  .busWrValid(busWrValid),
  .busWrAddr(busWrAddr),
  .busWrData(busWrData),
  .busWrReady(busWrReady),
  .busRdStrobe(busRdStrobe),
  .cellWrValid(cellWrValid),
  .cellWrAddr(cellWrAddr),
  .cellClearMask(cellClearMask),
  .cellWrReady(cellWrReady),
  .cellWrFail(cellWrFail),
  .pageAddr(pageAddr),
  .pageProtected(pageProtected),
  .readyBusyFlag(readyBusyFlag),
  .readMode(readMode),
  .failLocked(failLocked)
);

//--- testbench/fcp_array_model.sv
`timescale 1ns/1ps
// ----------
// flash array stand-in
// ----------
module fcp_array_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // programming port
  input wire logic cellWrValid,
  input wire logic [31:0] cellWrAddr,
  input wire logic [31:0] cellClearMask,
  output logic cellWrReady,
  output logic cellWrFail,
  // protection lookup
  input wire logic [31:0] pageAddr,
  output logic pageProtected,
  // scenario controls
  input wire logic slow,
  input wire logic failReq,
  input wire logic [31:0] protPage
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] tickQ;
  // slow mode takes one word in four so the write fifo backs up
  assign cellWrReady = !failReq && (!slow || tickQ == 2'h0);
  assign cellWrFail = failReq && cellWrValid;
  assign pageProtected = pageAddr[31:9] == protPage[31:9];
  // cells only fall to 0; unwritten words read as erased ones
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickQ <= 2'h0;
    end else begin
      tickQ <= tickQ + 2'h1;
      if (cellWrValid && cellWrReady) begin
        mem[cellWrAddr] = (mem.exists(cellWrAddr) ? mem[cellWrAddr] : 32'hFFFFFFFF)
          & ~cellClearMask;
      end
    end
  end
endmodule

//--- testbench/test_flash_command_page_program.sv
`timescale 1ns/1ps
module test_flash_command_page_program;
  // ----------
  // bench signals
  // ----------
  logic ref_clk = 1'b0, rst = 1'b1, busWrValid = 1'b0, busRdStrobe = 1'b0;
  logic slow = 1'b0, failReq = 1'b0;
  logic [31:0] busWrAddr = 32'h0, busWrData = 32'h0, protPage = 32'hFFFFFFFF;
  logic busWrReady, cellWrValid, cellWrReady, cellWrFail, pageProtected;
  logic readyBusyFlag, readMode, failLocked;
  logic [31:0] cellWrAddr, cellClearMask, pageAddr;
  logic [63:0] expQ[$];
  logic [31:0] lastA = 32'h0, lastD = 32'h0;
  int errCount = 0, checkCount = 0, seed = 8284;
  localparam logic [31:0] KA = {16'h0, fcp_pkg::KEY_ADDR_A};
  localparam logic [31:0] KB = {16'h0, fcp_pkg::KEY_ADDR_B};
  // 20 MHz clock
  initial forever #25 ref_clk = ~ref_clk;
  fcp_flash_seq i_dut (.ref_clk(ref_clk), .rst(rst), .busWrValid(busWrValid),
    .busWrAddr(busWrAddr), .busWrData(busWrData), .busWrReady(busWrReady),
    .busRdStrobe(busRdStrobe), .cellWrValid(cellWrValid), .cellWrAddr(cellWrAddr),
    .cellClearMask(cellClearMask), .cellWrReady(cellWrReady), .cellWrFail(cellWrFail),
    .pageAddr(pageAddr), .pageProtected(pageProtected), .readyBusyFlag(readyBusyFlag),
    .readMode(readMode), .failLocked(failLocked));
  fcp_array_model i_arr (.ref_clk(ref_clk), .rst(rst), .cellWrValid(cellWrValid),
    .cellWrAddr(cellWrAddr), .cellClearMask(cellClearMask), .cellWrReady(cellWrReady),
    .cellWrFail(cellWrFail), .pageAddr(pageAddr), .pageProtected(pageProtected),
    .slow(slow), .failReq(failReq), .protPage(protPage));
  // comparisons
  task automatic cmpWr(input logic [63:0] got, exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // status is sampled mid-cycle, clear of the launching edge
  task automatic cmpSt(input logic [2:0] exp);
    @(negedge ref_clk);
    cmpWr({61'h0, readyBusyFlag, readMode, failLocked}, {61'h0, exp});
    @(posedge ref_clk);
  endtask
  // one 32-bit write, held until the fifo takes it
  task automatic wr(input logic [31:0] a, d);
    logic r;
    busWrValid <= 1'b1;
    busWrAddr <= a;
    busWrData <= d;
    do begin
      @(negedge ref_clk);
      r = busWrReady;
      @(posedge ref_clk);
    end while (r !== 1'b1);
  endtask
  task automatic idle;
    busWrValid <= 1'b0;
    @(posedge ref_clk);
  endtask
  // broken entry followed by the tail of a valid one must stay idle
  task automatic tryAbort(input logic [31:0] a, d, input bit strobe);
    wr(KA, fcp_pkg::KEY_DATA_1);
    if (strobe) begin
      idle;
      busRdStrobe <= 1'b1;
      @(posedge ref_clk);
      busRdStrobe <= 1'b0;
    end else wr(a, d);
    wr(KB, fcp_pkg::KEY_DATA_2);
    wr(KA, fcp_pkg::CMD_PAGE_PROG);
    idle;
    repeat (10) @(posedge ref_clk);
    cmpSt(3'b110);
  endtask
  task automatic page(input logic [31:0] base, input bit expWr, input logic [2:0] mid);
    logic [31:0] d, a;
    busRdStrobe <= 1'b0;
    cmpSt(3'b110);
    wr(KA, fcp_pkg::KEY_DATA_1);
    wr(KB, fcp_pkg::KEY_DATA_2);
    wr(KA, fcp_pkg::CMD_PAGE_PROG);
    for (int i = 0; i < fcp_pkg::PAGE_WORDS; i++) begin
      d = (i == 3) ? fcp_pkg::CMD_READ : (i == 5) ? 32'hFFFFFFFF : $random(seed);
      a = base + 32'(i) * 32'h4;
      if (expWr) begin
        expQ.push_back({a, ~d});
        lastA = a;
        lastD = d;
      end
      wr(a, d);
      if (i == 20) begin
        idle;
        cmpSt(mid);
      end
    end
    idle;
  endtask
  task automatic done(input logic [2:0] exp);
    for (int n = 0; n < 3000 && readyBusyFlag !== 1'b1; n++) @(posedge ref_clk);
    cmpSt(exp);
    cmpWr(64'(expQ.size()), 64'h0);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // array writes are matched against the oldest note
  always @(posedge ref_clk) begin
    if (!rst && cellWrValid === 1'b1 && cellWrReady === 1'b1) begin
      if (expQ.size() == 0) cmpWr({cellWrAddr, cellClearMask}, 64'hX);
      else cmpWr({cellWrAddr, cellClearMask}, expQ.pop_front());
    end
  end
  // watchdog well past the longest expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    errCount++;
    results;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    cmpSt(3'b110);
    tryAbort(KB, 32'h00000057, 1'b0);
    tryAbort(32'h00000100, fcp_pkg::CMD_READ, 1'b0);
    tryAbort(32'h0, 32'h0, 1'b1);
    // three-cycle read/reset, then a page must still start cleanly
    wr(KA, fcp_pkg::KEY_DATA_1);
    wr(KB, fcp_pkg::KEY_DATA_2);
    wr(KB, fcp_pkg::CMD_READ);
    idle;
    repeat (10) @(posedge ref_clk);
    cmpSt(3'b110);
    $display("test done: aborts");
    slow <= 1'b1;
    page(($random(seed) & 32'h000FFE00) | 32'h00100000, 1'b1, 3'b000);
    done(3'b110);
    cmpWr({32'h0, i_arr.mem[lastA]}, {32'h0, lastD});
    slow <= 1'b0;
    $display("test done: page");
    protPage <= 32'h00004000;
    page(32'h00004000, 1'b0, 3'b000);
    done(3'b110);
    $display("test done: protected");
    failReq <= 1'b1;
    page(32'h00006000, 1'b0, 3'b001);
    done(3'b001);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    failReq <= 1'b0;
    cmpSt(3'b110);
    $display("test done: failure");
    // the interrupted page is still erased in the stand-in, so program it anew
    page(32'h00006000, 1'b1, 3'b000);
    done(3'b110);
    cmpWr({32'h0, i_arr.mem[lastA]}, {32'h0, lastD});
    $display("test done: reprogram");
    results;
  end
endmodule
